/* File: rtl/tpsc_sram_ctrl.sv */
// shared 3 MB sram behind three 128-bit axi subordinate ports
// assumes byte addresses local to the sram window and one clock for all
// Function
// - three independent 128-bit axi subordinate ports
// - port0 dma, port1 graphics/display, port2 cpu
// - 128 kB banks; conflicts only within one bank
// - up to three accesses per cycle, distinct banks
// - every port reaches the full 3 MB
// - three independently powered memory domains
// - everything synchronous to one clock
`timescale 1ns/100ps
`default_nettype none
`include "tpsc_cfg.svh"

module tpsc_sram_ctrl (
  // clock and reset
  input  wire logic                     ref_clk_in,
  input  wire logic                     reset_in,
  // port0: dma
  input  wire tpsc_pkg::tpsc_axi_req_t  dma_axi_req_in,
  output tpsc_pkg::tpsc_axi_rsp_t       dma_axi_rsp_out,
  // port1: graphics and display
  input  wire tpsc_pkg::tpsc_axi_req_t  gfx_axi_req_in,
  output tpsc_pkg::tpsc_axi_rsp_t       gfx_axi_rsp_out,
  // port2: cpu
  input  wire tpsc_pkg::tpsc_axi_req_t  cpu_axi_req_in,
  output tpsc_pkg::tpsc_axi_rsp_t       cpu_axi_rsp_out,
  // power domains and status
  input  wire logic [`TPSC_NUM_DOMAINS-1:0] domain_power_en_in,
  output logic [`TPSC_NUM_PORTS-1:0]        conflict_stall_out
);
  import tpsc_pkg::*;

  typedef struct packed {
    logic [`TPSC_NUM_BANKS-1:0][1:0]                   rr;
    logic [`TPSC_NUM_PORTS-1:0][`TPSC_DATA_W-1:0]      rdata;
    logic [`TPSC_NUM_PORTS-1:0]                        stall;
  } tpsc_ctrl_state_t;

  tpsc_ctrl_state_t cur;
  tpsc_ctrl_state_t next_cur;

  logic [`TPSC_DATA_W-1:0] mem [0:`TPSC_WORDS-1];

  tpsc_axi_req_t  axi_req [`TPSC_NUM_PORTS];
  tpsc_axi_rsp_t  axi_rsp [`TPSC_NUM_PORTS];
  tpsc_mem_req_t  mreq    [`TPSC_NUM_PORTS];
  tpsc_mem_rsp_t  mrsp    [`TPSC_NUM_PORTS];
  logic [`TPSC_BANK_W-1:0] bank [`TPSC_NUM_PORTS];
  logic [`TPSC_NUM_PORTS-1:0] ok;
  logic [`TPSC_NUM_PORTS-1:0] grant;
  logic [`TPSC_NUM_PORTS-1:0] lost;

  // fixed requestor per port
  assign axi_req[`TPSC_PORT_DMA] = dma_axi_req_in;
  assign axi_req[`TPSC_PORT_GFX] = gfx_axi_req_in;
  assign axi_req[`TPSC_PORT_CPU] = cpu_axi_req_in;
  assign dma_axi_rsp_out = axi_rsp[`TPSC_PORT_DMA];
  assign gfx_axi_rsp_out = axi_rsp[`TPSC_PORT_GFX];
  assign cpu_axi_rsp_out = axi_rsp[`TPSC_PORT_CPU];
  assign conflict_stall_out = cur.stall;

  // true when port p outranks port q under pointer ptr
  function automatic logic tpsc_outranks(input int p, input int q, input logic [1:0] ptr);
    int dp;
    int dq;
    dp = (p + `TPSC_NUM_PORTS - int'(ptr)) % `TPSC_NUM_PORTS;
    dq = (q + `TPSC_NUM_PORTS - int'(ptr)) % `TPSC_NUM_PORTS;
    return dp < dq;
  endfunction : tpsc_outranks

  genvar gp;
  generate
    for (gp = 0; gp < `TPSC_NUM_PORTS; gp++)
    begin : g_port
      // each port runs its own engine, none waits on another's protocol
      tpsc_port_engine u_engine (
        .ref_clk_in  (ref_clk_in),
        .reset_in    (reset_in),
        .axi_req_in  (axi_req[gp]),
        .axi_rsp_out (axi_rsp[gp]),
        .mem_req_out (mreq[gp]),
        .mem_rsp_in  (mrsp[gp]),
        .rd_data_in  (cur.rdata[gp])
      );

      // 128 kB bank index from the word address
      assign bank[gp] = mreq[gp].addr[`TPSC_WORD_W-1:`TPSC_BANK_WORD_LSB];
      // in range of 3 MB and the bank's domain powered
      assign ok[gp] = (bank[gp] < `TPSC_BANK_W'(`TPSC_NUM_BANKS))
                    && domain_power_en_in[2'(bank[gp] / `TPSC_BANKS_PER_DOMAIN)];
      assign mrsp[gp].grant = grant[gp];
      assign mrsp[gp].err   = !ok[gp];
    end
  endgenerate

  // bank arbitration: only same-bank requests compete
  always_comb
  begin
    grant = '0;
    lost  = '0;
    for (int p = 0; p < `TPSC_NUM_PORTS; p++)
    begin
      grant[p] = mreq[p].valid;
      for (int q = 0; q < `TPSC_NUM_PORTS; q++)
      begin
        if (q != p && ok[p] && ok[q] && mreq[q].valid && mreq[p].valid
            && bank[q] == bank[p]
            && !tpsc_outranks(p, q, cur.rr[bank[p]]))
        begin
          grant[p] = 1'b0;
          lost[p]  = 1'b1;
        end
      end
    end
  end

  always_comb
  begin
    next_cur       = cur;
    next_cur.stall = lost;
    for (int p = 0; p < `TPSC_NUM_PORTS; p++)
    begin
      // winner moves to the back of its bank's order
      if (grant[p] && ok[p] && (lost != '0))
        next_cur.rr[bank[p]] = 2'((p + 1) % `TPSC_NUM_PORTS);
      // distinct banks read in the same cycle
      if (grant[p] && ok[p] && !mreq[p].write)
        next_cur.rdata[p] = mem[mreq[p].addr];
      else if (grant[p] && !mreq[p].write)
        next_cur.rdata[p] = '0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
      cur <= '0;
    else
      cur <= next_cur;
  end

  // up to three byte-masked writes per cycle, never to one bank
  always_ff @(posedge ref_clk_in)
  begin
    for (int p = 0; p < `TPSC_NUM_PORTS; p++)
    begin
      if (grant[p] && ok[p] && mreq[p].write)
      begin
        for (int b = 0; b < `TPSC_STRB_W; b++)
        begin
          if (mreq[p].strb[b])
            mem[mreq[p].addr][b*8 +: 8] <= mreq[p].data[b*8 +: 8];
        end
      end
    end
  end

endmodule : tpsc_sram_ctrl

`default_nettype wire

/* File: rtl/tpsc_cfg.svh */
// constants for the triple-port shared sram controller
// assumes byte addresses local to the sram window, starting at zero
`ifndef TPSC_CFG_SVH
`define TPSC_CFG_SVH

`define TPSC_NUM_PORTS         3
`define TPSC_PORT_DMA          0
`define TPSC_PORT_GFX          1
`define TPSC_PORT_CPU          2
`define TPSC_DATA_W            128
`define TPSC_STRB_W            16
`define TPSC_ADDR_W            22
`define TPSC_LEN_W             8
`define TPSC_ID_W              4
`define TPSC_WORD_LSB          4
`define TPSC_WORD_W            18
`define TPSC_BANK_WORD_LSB     13
`define TPSC_BANK_W            5
`define TPSC_NUM_BANKS         24
`define TPSC_WORDS             196608
`define TPSC_NUM_DOMAINS       3
`define TPSC_BANKS_PER_DOMAIN  8
`define TPSC_RESP_OKAY         2'h0
`define TPSC_RESP_SLVERR       2'h2
`define TPSC_CLK_MHZ           96

`endif

/* File: rtl/tpsc_pkg.sv */
// types shared by the sram controller and its port engines
// assumes tpsc_cfg.svh supplies all widths except the state and resp fields
`include "tpsc_cfg.svh"

package tpsc_pkg;

  typedef struct packed {
    logic                     aw_valid;
    logic [`TPSC_ID_W-1:0]    aw_id;
    logic [`TPSC_ADDR_W-1:0]  aw_addr;
    logic [`TPSC_LEN_W-1:0]   aw_len;
    logic                     w_valid;
    logic [`TPSC_DATA_W-1:0]  w_data;
    logic [`TPSC_STRB_W-1:0]  w_strb;
    logic                     w_last;
    logic                     b_ready;
    logic                     ar_valid;
    logic [`TPSC_ID_W-1:0]    ar_id;
    logic [`TPSC_ADDR_W-1:0]  ar_addr;
    logic [`TPSC_LEN_W-1:0]   ar_len;
    logic                     r_ready;
  } tpsc_axi_req_t;

  typedef struct packed {
    logic                     aw_ready;
    logic                     w_ready;
    logic                     b_valid;
    logic [`TPSC_ID_W-1:0]    b_id;
    logic [1:0]               b_resp;
    logic                     ar_ready;
    logic                     r_valid;
    logic [`TPSC_ID_W-1:0]    r_id;
    logic [`TPSC_DATA_W-1:0]  r_data;
    logic [1:0]               r_resp;
    logic                     r_last;
  } tpsc_axi_rsp_t;

  typedef struct packed {
    logic                     valid;
    logic                     write;
    logic [`TPSC_WORD_W-1:0]  addr;
    logic [`TPSC_DATA_W-1:0]  data;
    logic [`TPSC_STRB_W-1:0]  strb;
  } tpsc_mem_req_t;

  typedef struct packed {
    logic grant;
    logic err;
  } tpsc_mem_rsp_t;

  typedef enum logic [4:0] {
    TPSC_IDLE  = 5'h01,
    TPSC_WR    = 5'h02,
    TPSC_WRESP = 5'h04,
    TPSC_RD    = 5'h08,
    TPSC_RDATA = 5'h10
  } tpsc_state_t;

  typedef struct packed {
    tpsc_state_t              st;
    logic [`TPSC_ID_W-1:0]    id;
    logic [`TPSC_WORD_W-1:0]  addr;
    logic [`TPSC_LEN_W-1:0]   count;
    logic [1:0]               resp;
    logic                     pick_read;
  } tpsc_port_state_t;

endpackage : tpsc_pkg

/* File: rtl/tpsc_port_engine.sv */
// one axi subordinate port: single outstanding transaction, incr bursts
// assumes full-width beats and a same-cycle grant from the bank arbiter
`timescale 1ns/100ps
`default_nettype none
`include "tpsc_cfg.svh"

module tpsc_port_engine (
  // clock and reset
  input  wire logic                     ref_clk_in,
  input  wire logic                     reset_in,
  // axi side
  input  wire tpsc_pkg::tpsc_axi_req_t  axi_req_in,
  output tpsc_pkg::tpsc_axi_rsp_t       axi_rsp_out,
  // array side
  output tpsc_pkg::tpsc_mem_req_t       mem_req_out,
  input  wire tpsc_pkg::tpsc_mem_rsp_t  mem_rsp_in,
  input  wire logic [`TPSC_DATA_W-1:0]  rd_data_in
);
  import tpsc_pkg::*;

  tpsc_port_state_t cur;
  tpsc_port_state_t next_cur;

  always_comb
  begin
    next_cur    = cur;
    axi_rsp_out = '0;
    mem_req_out = '0;
    case (cur.st)
      TPSC_IDLE:
      begin
        // alternate between write and read when both wait
        if (axi_req_in.aw_valid && !(axi_req_in.ar_valid && cur.pick_read))
        begin
          axi_rsp_out.aw_ready = 1'b1;
          next_cur.id          = axi_req_in.aw_id;
          next_cur.addr        = axi_req_in.aw_addr[`TPSC_ADDR_W-1:`TPSC_WORD_LSB];
          next_cur.count       = axi_req_in.aw_len;
          next_cur.resp        = `TPSC_RESP_OKAY;
          next_cur.pick_read   = 1'b1;
          next_cur.st          = TPSC_WR;
        end
        else if (axi_req_in.ar_valid)
        begin
          axi_rsp_out.ar_ready = 1'b1;
          next_cur.id          = axi_req_in.ar_id;
          next_cur.addr        = axi_req_in.ar_addr[`TPSC_ADDR_W-1:`TPSC_WORD_LSB];
          next_cur.count       = axi_req_in.ar_len;
          next_cur.pick_read   = 1'b0;
          next_cur.st          = TPSC_RD;
        end
      end
      TPSC_WR:
      begin
        mem_req_out.valid   = axi_req_in.w_valid;
        mem_req_out.write   = 1'b1;
        mem_req_out.addr    = cur.addr;
        mem_req_out.data    = axi_req_in.w_data;
        mem_req_out.strb    = axi_req_in.w_strb;
        axi_rsp_out.w_ready = mem_rsp_in.grant;
        if (axi_req_in.w_valid && mem_rsp_in.grant)
        begin
          if (mem_rsp_in.err)
            next_cur.resp = `TPSC_RESP_SLVERR;
          next_cur.addr = cur.addr + `TPSC_WORD_W'(1);
          if (axi_req_in.w_last || cur.count == '0)
            next_cur.st = TPSC_WRESP;
          else
            next_cur.count = cur.count - `TPSC_LEN_W'(1);
        end
      end
      TPSC_WRESP:
      begin
        axi_rsp_out.b_valid = 1'b1;
        axi_rsp_out.b_id    = cur.id;
        axi_rsp_out.b_resp  = cur.resp;
        if (axi_req_in.b_ready)
          next_cur.st = TPSC_IDLE;
      end
      TPSC_RD:
      begin
        mem_req_out.valid = 1'b1;
        mem_req_out.addr  = cur.addr;
        if (mem_rsp_in.grant)
        begin
          next_cur.resp = mem_rsp_in.err ? `TPSC_RESP_SLVERR : `TPSC_RESP_OKAY;
          next_cur.addr = cur.addr + `TPSC_WORD_W'(1);
          next_cur.st   = TPSC_RDATA;
        end
      end
      TPSC_RDATA:
      begin
        axi_rsp_out.r_valid = 1'b1;
        axi_rsp_out.r_id    = cur.id;
        axi_rsp_out.r_data  = rd_data_in;
        axi_rsp_out.r_resp  = cur.resp;
        axi_rsp_out.r_last  = (cur.count == '0);
        if (axi_req_in.r_ready)
        begin
          if (cur.count == '0)
            next_cur.st = TPSC_IDLE;
          else
          begin
            next_cur.count = cur.count - `TPSC_LEN_W'(1);
            next_cur.st    = TPSC_RD;
          end
        end
      end
      default:
        next_cur.st = TPSC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cur    <= '0;
      cur.st <= TPSC_IDLE;
    end
    else
      cur <= next_cur;
  end

endmodule : tpsc_port_engine

`default_nettype wire

/* File: verif/tpsc_sram_ctrl_properties.sv */
// port checker for the shared sram controller
// assumes bind from the bench top and one clock domain
`timescale 1ns/100ps
`default_nettype none

module tpsc_sram_ctrl_properties (
  // clock and reset
  input wire logic                    ref_clk_in,
  input wire logic                    reset_in,
  // axi ports
  input wire tpsc_pkg::tpsc_axi_req_t dma_axi_req_in,
  input wire tpsc_pkg::tpsc_axi_rsp_t dma_axi_rsp_out,
  input wire tpsc_pkg::tpsc_axi_req_t gfx_axi_req_in,
  input wire tpsc_pkg::tpsc_axi_rsp_t gfx_axi_rsp_out,
  input wire tpsc_pkg::tpsc_axi_req_t cpu_axi_req_in,
  input wire tpsc_pkg::tpsc_axi_rsp_t cpu_axi_rsp_out,
  // power and status
  input wire logic [2:0]              domain_power_en_in,
  input wire logic [2:0]              conflict_stall_out
);
  import tpsc_pkg::*;
  wire tpsc_axi_req_t dq = dma_axi_req_in;
  wire tpsc_axi_rsp_t ds = dma_axi_rsp_out;
  wire tpsc_axi_req_t gq = gfx_axi_req_in;
  wire tpsc_axi_rsp_t gs = gfx_axi_rsp_out;
  wire tpsc_axi_req_t cq = cpu_axi_req_in;
  wire tpsc_axi_rsp_t cs = cpu_axi_rsp_out;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  AST_B_AFTER_LAST: assert property (
    dq.w_valid && ds.w_ready && dq.w_last |=> ds.b_valid) else $error("late write reply");
  AST_B_HOLD: assert property (
    gs.b_valid && !gq.b_ready |=> gs.b_valid && $stable(gs.b_resp)) else $error("b dropped");
  AST_R_HOLD: assert property (
    cs.r_valid && !cq.r_ready |=> cs.r_valid && $stable(cs.r_data)) else $error("r dropped");
  AST_ONE_OPEN: assert property (
    gs.b_valid || gs.r_valid |-> !gs.aw_ready && !gs.ar_ready) else $error("second open");
  AST_ONE_WINNER: assert property (
    $countones(conflict_stall_out) < 3) else $error("no port granted");
  AST_ERR_ZERO: assert property (
    ds.r_valid && ds.r_resp == 2'h2 |-> ds.r_data == '0) else $error("error data");
  AST_RD_LAT: assert property (
    cq.ar_valid && cs.ar_ready |=> !cs.r_valid ##[1:40] cs.r_valid) else $error("read slow");
  AST_STALL_CAUSE: assert property (
    conflict_stall_out[1] |-> $past(!gs.b_valid && !gs.r_valid)) else $error("odd stall");
endmodule : tpsc_sram_ctrl_properties

`default_nettype wire

/* File: verif/tpsc_mgr_model.sv */
// single-beat axi manager standing in for one requestor
// assumes start pulses only while idle; slow halves b and r ready
`timescale 1ns/100ps
`default_nettype none

module tpsc_mgr_model (
  // control
  input  wire logic                    clk_in,
  input  wire logic                    start_in,
  input  wire logic                    wr_in,
  input  wire logic                    slow_in,
  input  wire logic [21:0]             addr_in,
  input  wire logic [127:0]            data_in,
  // axi
  input  wire tpsc_pkg::tpsc_axi_rsp_t rsp_in,
  output var tpsc_pkg::tpsc_axi_req_t  req_out,
  // result
  output var logic                     done_out,
  output var logic [127:0]             rdata_out,
  output var logic [1:0]               resp_out
);
  tpsc_pkg::tpsc_axi_req_t req  = '0;
  logic                    done = 1'b0;
  logic                    tg   = 1'b0;

  assign req_out  = req;
  assign done_out = done;

  always @(posedge clk_in)
  begin
    tg <= ~tg;
    done <= 1'b0;
    req.b_ready <= ~slow_in | tg;
    req.r_ready <= ~slow_in | tg;
    // released lines stop showing old values
    if (req.aw_valid && rsp_in.aw_ready)
    begin
      req.aw_valid <= 1'b0;
      req.aw_addr <= ~req.aw_addr;
    end
    if (req.w_valid && rsp_in.w_ready)
    begin
      req.w_valid <= 1'b0;
      req.w_data <= ~req.w_data;
    end
    if (req.ar_valid && rsp_in.ar_ready)
    begin
      req.ar_valid <= 1'b0;
      req.ar_addr <= ~req.ar_addr;
    end
    if (rsp_in.b_valid && req.b_ready)
    begin
      done <= 1'b1;
      resp_out <= rsp_in.b_resp;
    end
    if (rsp_in.r_valid && req.r_ready && rsp_in.r_last)
    begin
      done <= 1'b1;
      resp_out <= rsp_in.r_resp;
      rdata_out <= rsp_in.r_data;
    end
    if (start_in)
    begin
      req.aw_valid <= wr_in;
      req.w_valid <= wr_in;
      req.ar_valid <= ~wr_in;
      req.aw_addr <= addr_in;
      req.ar_addr <= addr_in;
      req.w_data <= data_in;
      req.w_strb <= 16'hffff;
      req.w_last <= 1'b1;
    end
  end
endmodule : tpsc_mgr_model

`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the shared sram controller
// assumes one manager model per port and the bound checker
`timescale 1ns/100ps
`default_nettype none

module tb;
  import tpsc_pkg::*;
  logic          ref_clk_in = 1'b0;
  logic          reset_in = 1'b1;
  logic          wr = 1'b0;
  logic [2:0]    go = 3'h0;
  logic [2:0]    pwr = 3'h7;
  logic [2:0]    slow = 3'h0;
  logic [2:0]    stl;
  logic [2:0]    dn;
  logic [2:0]    cs;
  logic [21:0]   ad [3];
  logic [127:0]  wd [3];
  logic [127:0]  rd [3];
  logic [1:0]    rs [3];
  tpsc_axi_req_t rq [3];
  tpsc_axi_rsp_t rp [3];
  int            n_errors = 0;
  int            samples_checked = 0;

  always #50 ref_clk_in = ~ref_clk_in;

  for (genvar i = 0; i < 3; i++)
  begin : g_mgr
    tpsc_mgr_model u_mgr (.clk_in(ref_clk_in), .start_in(go[i]), .wr_in(wr),
      .slow_in(slow[i]), .addr_in(ad[i]), .data_in(wd[i]), .rsp_in(rp[i]),
      .req_out(rq[i]), .done_out(dn[i]), .rdata_out(rd[i]), .resp_out(rs[i]));
  end

  tpsc_sram_ctrl DUT (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .dma_axi_req_in(rq[0]), .dma_axi_rsp_out(rp[0]),
    .gfx_axi_req_in(rq[1]), .gfx_axi_rsp_out(rp[1]),
    .cpu_axi_req_in(rq[2]), .cpu_axi_rsp_out(rp[2]),
    .domain_power_en_in(pwr), .conflict_stall_out(cs));

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic prep(input logic [21:0] a0, a1, a2, input logic [127:0] x);
    ad[0] <= a0;
    ad[1] <= a1;
    ad[2] <= a2;
    wd[0] <= {4{10'h155, a0}} ^ x;
    wd[1] <= {4{10'h155, a1}} ^ x;
    wd[2] <= {4{10'h155, a2}} ^ x;
  endtask : prep

  task automatic xfer(input logic [2:0] m, input logic w);
    logic [2:0] got;
    got = 3'h0;
    stl = 3'h0;
    @(posedge ref_clk_in);
    wr <= w;
    go <= m;
    @(posedge ref_clk_in);
    go <= 3'h0;
    for (int k = 0; k < 200 && got != m; k++)
    begin
      @(posedge ref_clk_in);
      got = got | dn;
      stl = stl | cs;
    end
    chk(got, m);
  endtask : xfer

  task automatic t_conc;
    prep(22'h01fff0, 22'h020000, 22'h2ffff0, 128'h0);
    xfer(3'h7, 1'b1);
    chk(stl, 3'h0);
    prep(22'h2ffff0, 22'h01fff0, 22'h020000, 128'h0);
    xfer(3'h7, 1'b0);
    chk(stl, 3'h0);
    for (int i = 0; i < 3; i++)
      chk(rd[i], wd[i]);
  endtask : t_conc

  task automatic t_clash;
    slow <= 3'h7;
    prep(22'h0a0000, 22'h0a0010, 22'h0a0020, 128'h0);
    xfer(3'h7, 1'b1);
    chk(stl != 3'h0, 1'b1);
    xfer(3'h7, 1'b0);
    for (int i = 0; i < 3; i++)
      chk(rd[i], wd[i]);
    slow <= 3'h0;
    prep(22'h0c0000, 22'h0c0010, 22'h100000, 128'h0);
    xfer(3'h7, 1'b1);
    chk(stl[2], 1'b0);
  endtask : t_clash

  task automatic t_edge;
    prep(22'h300000, 22'h3ffff0, 22'h2fff00, 128'h0);
    xfer(3'h7, 1'b1);
    chk(rs[0], 2'h2);
    chk(rs[1], 2'h2);
    chk(rs[2], 2'h0);
    xfer(3'h1, 1'b0);
    chk(rd[0], 128'h0);
  endtask : t_edge

  task automatic t_power;
    // known content first, so a write that lands while unpowered shows
    prep(22'h000100, 22'h120100, 22'h240100, 128'h0);
    xfer(3'h1, 1'b1);
    chk(rs[0], 2'h0);
    pwr <= 3'h6;
    prep(22'h000100, 22'h120100, 22'h240100, {128{1'b1}});
    xfer(3'h7, 1'b1);
    chk(rs[0], 2'h2);
    chk(rs[1], 2'h0);
    pwr <= 3'h7;
    prep(22'h000100, 22'h120100, 22'h240100, 128'h0);
    xfer(3'h3, 1'b0);
    chk(rd[0], wd[0]);
    chk(rd[1], ~wd[1]);
  endtask : t_power

  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (5) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    t_conc;
    t_clash;
    t_edge;
    t_power;
    summarize;
  end

  initial
  begin
    #2000000;
    n_errors++;
    summarize;
  end
endmodule : tb

bind tpsc_sram_ctrl tpsc_sram_ctrl_properties u_props (.ref_clk_in, .reset_in,
  .dma_axi_req_in, .dma_axi_rsp_out, .gfx_axi_req_in, .gfx_axi_rsp_out,
  .cpu_axi_req_in, .cpu_axi_rsp_out, .domain_power_en_in, .conflict_stall_out);

`default_nettype wire
